// >>> include/can_mode_cfg.svh
// constants for the can operating-mode controller: offsets, fields, resets, timing
// assumes a single 40 MHz clock and an apb register port with 32-bit data
//
// Contract
// RL1: software requests a mode through the 3-bit request field, can_control_1 bits 10:8
// RL2: the mode actually entered is shown in can_control_1 bits 7:5
// RL3: mode change and status update wait until 11 recessive bits seen; from init or disable mode the code changes at once
// RL4: initialization mode: no transmit or receive, error counters cleared, flags kept
// RL5: configuration registers are writable only in initialization mode
// RL6: initialization mode is not entered while a transmission runs
// RL7: disable mode: no transmit or receive, interrupts pending, error counters held
// RL8: in disable mode bus activity sets the wake event flag
// RL9: disable request from an active mode waits for 11 recessive bits
// RL10: status reads 001 once disable mode has been entered
// RL11: disable mode releases both bus pins to general-purpose use
// RL12: wake filter enable low-pass filters the receive pin while asleep
// RL13: after entering a transmitting mode, transmission waits 11 recessive bits
// RL14: disable request during that hold-off aborts the transmission and flags it
// RL15: request 000 enters normal mode, transmitting and receiving on the pins
// RL16: request 111 ignores errors and keeps data captured up to an error
// RL17: listen-only is passive, no acks or error flags, counters off, tx pin released
// RL18: loopback ties internal transmit to internal receive, both pins released
// RL19: idle count restarts on every dominant bit sampled
// RL20: unsupported request codes leave mode and status unchanged
`ifndef CAN_MODE_CFG_SVH
`define CAN_MODE_CFG_SVH
// =====================================================================
// register byte offsets
`define OFS_CONTROL_1 12'h000
`define OFS_CONFIG_2 12'h004
`define OFS_BIT_TIMING 12'h008
`define OFS_ACCEPT_FILTER 12'h00c
`define OFS_ACCEPT_MASK 12'h010
`define OFS_STATUS 12'h014
// =====================================================================
// field positions
`define REQ_HI 10
`define REQ_LO 8
`define STAT_HI 7
`define STAT_LO 5
`define WAKE_FILT_BIT 14
`define ST_WAKE_BIT 0
`define ST_ABORT_BIT 1
`define ST_SEND_BIT 2
`define ST_ERR_HI 15
`define ST_ERR_LO 8
// =====================================================================
// mode codes
`define CODE_NORMAL 3'h0
`define CODE_DISABLE 3'h1
`define CODE_LOOPBACK 3'h2
`define CODE_LISTEN_ONLY 3'h3
`define CODE_INIT 3'h4
`define CODE_LISTEN_ALL 3'h7
// =====================================================================
// resets and timing
`define RESET_TIMING 16'h0003
`define IDLE_BITS 4'hb
`define ERR_MAX 8'hff
`define CLK_MHZ 40
`define WAKE_FILT_NS 500
`define WAKE_FILT_CYC (((`WAKE_FILT_NS) * (`CLK_MHZ) + 999) / 1000)
`endif

// >>> include/can_mode_pkg.sv
// types for the can operating-mode controller
// assumes can_mode_cfg.svh holds the numbers
package can_mode_pkg;
  // =====================================================================
  // operating modes
  typedef enum logic [2:0] {
    mode_normal, mode_disable, mode_loopback, mode_listen_only, mode_init, mode_listen_all
  } mode_t;
  // signals from the protocol engine
  typedef struct packed {
    logic tx_bit;   // engine serial transmit level
    logic tx_busy;  // frame being sent
    logic tx_done;  // one-cycle pulse, frame sent
    logic err_evt;  // one-cycle pulse, protocol error
  } engine_in_t;
  // enables handed to the protocol engine
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic ack_enable;
    logic err_flag_enable;
    logic keep_on_error;
    logic loopback;
  } mode_ctl_t;
endpackage

// >>> verilog/can_operating_mode_control.sv
// operating-mode controller of a can module: apb registers, mode sequencing,
// idle detection, wake detection, transmit hold-off and pin ownership
// assumes the protocol engine and port muxing sit outside; inputs synchronous to pclk
`timescale 1ns/100ps
`include "can_mode_cfg.svh"
module can_operating_mode_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus pins
  input wire logic can_receive_pin,
  output logic can_transmit_pin,
  output logic can_transmit_pin_oe,
  output logic receive_pin_claimed,
  // protocol engine
  input wire can_mode_pkg::engine_in_t engine_in,
  output can_mode_pkg::mode_ctl_t mode_ctl,
  output logic engine_rx,
  output logic bit_tick,
  output logic tx_go,
  // configuration held for the engine
  output logic [15:0] bit_timing,
  output logic [31:0] accept_filter,
  output logic [31:0] accept_mask,
  // system
  input wire logic cpu_sleep
);

  // =====================================================================
  // helpers
  function automatic logic code_valid(input logic [2:0] c);
    code_valid = (c == `CODE_NORMAL) || (c == `CODE_DISABLE) || (c == `CODE_LOOPBACK) ||
                 (c == `CODE_LISTEN_ONLY) || (c == `CODE_INIT) || (c == `CODE_LISTEN_ALL);
  endfunction

  function automatic can_mode_pkg::mode_t code_to_mode(input logic [2:0] c);
    case (c)
      `CODE_NORMAL: code_to_mode = can_mode_pkg::mode_normal;
      `CODE_DISABLE: code_to_mode = can_mode_pkg::mode_disable;
      `CODE_LOOPBACK: code_to_mode = can_mode_pkg::mode_loopback;
      `CODE_LISTEN_ONLY: code_to_mode = can_mode_pkg::mode_listen_only;
      `CODE_LISTEN_ALL: code_to_mode = can_mode_pkg::mode_listen_all;
      default: code_to_mode = can_mode_pkg::mode_init;
    endcase
  endfunction

  function automatic logic [2:0] mode_to_code(input can_mode_pkg::mode_t m);
    case (m)
      can_mode_pkg::mode_normal: mode_to_code = `CODE_NORMAL;
      can_mode_pkg::mode_disable: mode_to_code = `CODE_DISABLE;
      can_mode_pkg::mode_loopback: mode_to_code = `CODE_LOOPBACK;
      can_mode_pkg::mode_listen_only: mode_to_code = `CODE_LISTEN_ONLY;
      can_mode_pkg::mode_listen_all: mode_to_code = `CODE_LISTEN_ALL;
      default: mode_to_code = `CODE_INIT;
    endcase
  endfunction

  function automatic logic tx_mode(input can_mode_pkg::mode_t m);
    tx_mode = (m == can_mode_pkg::mode_normal) || (m == can_mode_pkg::mode_loopback);
  endfunction

  // =====================================================================
  // state
  can_mode_pkg::mode_t mode;
  logic [2:0] mode_request;
  logic wake_filter_enable;
  logic wake_event_flag;
  logic tx_aborted_flag;
  logic tx_send_request;
  logic [7:0] err_count;
  logic [3:0] idle_count;
  logic [15:0] prescale_count;
  logic [7:0] wake_count;
  logic holdoff;

  logic idle_seen;
  logic wr_ok;
  logic rd_sel;
  logic locked_hit;
  logic mode_go;
  logic disable_req_wr;
  logic rx_bus;
  logic [31:0] rd_word;
  logic addr_hit;

  assign idle_seen = (idle_count == `IDLE_BITS);
  assign rx_bus = (mode == can_mode_pkg::mode_loopback) ? engine_in.tx_bit : can_receive_pin;
  // write commits at the access edge where pready is sampled high
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign rd_sel = psel && !penable;
  // locked registers only in initialization mode
  assign locked_hit = (paddr == `OFS_CONFIG_2) || (paddr == `OFS_BIT_TIMING) ||
                      (paddr == `OFS_ACCEPT_FILTER) || (paddr == `OFS_ACCEPT_MASK); // RL5
  assign disable_req_wr = wr_ok && (paddr == `OFS_CONTROL_1) &&
                          (pwdata[`REQ_HI:`REQ_LO] == `CODE_DISABLE);

  // mode change: unsupported codes never move the mode
  always_comb begin
    mode_go = 1'b0;
    if (code_valid(mode_request) && (code_to_mode(mode_request) != mode)) begin // RL20
      if ((mode == can_mode_pkg::mode_init) || (mode == can_mode_pkg::mode_disable)) begin
        mode_go = 1'b1; // offline, nothing on the bus to disturb
      end else if (idle_seen) begin // RL3 RL9
        // no configuration lock while a frame is still going out
        mode_go = !((mode_request == `CODE_INIT) && engine_in.tx_busy); // RL6
      end
    end
  end

  // register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `OFS_CONTROL_1: begin
        rd_word[`REQ_HI:`REQ_LO] = mode_request;
        rd_word[`STAT_HI:`STAT_LO] = mode_to_code(mode); // RL2
      end
      `OFS_CONFIG_2: rd_word[`WAKE_FILT_BIT] = wake_filter_enable;
      `OFS_BIT_TIMING: rd_word[15:0] = bit_timing;
      `OFS_ACCEPT_FILTER: rd_word = accept_filter;
      `OFS_ACCEPT_MASK: rd_word = accept_mask;
      `OFS_STATUS: begin
        rd_word[`ST_WAKE_BIT] = wake_event_flag;
        rd_word[`ST_ABORT_BIT] = tx_aborted_flag;
        rd_word[`ST_SEND_BIT] = tx_send_request;
        rd_word[`ST_ERR_HI:`ST_ERR_LO] = err_count;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // =====================================================================
  // apb answer: one wait-free access phase after each setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_sel;
      if (rd_sel) begin
        // unmapped address, or locked register written outside init
        pslverr <= !addr_hit ||
                   (pwrite && locked_hit && (mode != can_mode_pkg::mode_init)); // RL5
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // mode request field, written any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_request <= `CODE_INIT;
    end else if (wr_ok && (paddr == `OFS_CONTROL_1)) begin
      mode_request <= pwdata[`REQ_HI:`REQ_LO]; // RL1
    end
  end

  // configuration registers, refused by pslverr outside init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_filter_enable <= 1'b0;
      bit_timing <= `RESET_TIMING;
      accept_filter <= 32'h0000_0000;
      accept_mask <= 32'h0000_0000;
    end else if (wr_ok) begin
      case (paddr)
        `OFS_CONFIG_2: wake_filter_enable <= pwdata[`WAKE_FILT_BIT];
        `OFS_BIT_TIMING: bit_timing <= pwdata[15:0];
        `OFS_ACCEPT_FILTER: accept_filter <= pwdata;
        `OFS_ACCEPT_MASK: accept_mask <= pwdata;
        default: ;
      endcase
    end
  end

  // =====================================================================
  // operating mode, status follows only on an accepted change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= can_mode_pkg::mode_init;
    end else if (mode_go) begin
      mode <= code_to_mode(mode_request); // RL3 RL10 RL15 RL16
    end
  end

  // bit-time divider: tick every bit_timing+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 16'h0000;
      bit_tick <= 1'b0;
    end else if (prescale_count >= bit_timing) begin
      prescale_count <= 16'h0000;
      bit_tick <= 1'b1;
    end else begin
      prescale_count <= prescale_count + 16'h0001;
      bit_tick <= 1'b0;
    end
  end

  // idle detector: restarts on a dominant bit and on each mode entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_count <= 4'h0;
    end else if (mode_go) begin
      idle_count <= 4'h0; // RL13
    end else if (bit_tick) begin
      if (!rx_bus) begin
        idle_count <= 4'h0; // RL19
      end else if (!idle_seen) begin
        idle_count <= idle_count + 4'h1;
      end
    end
  end

  // transmit hold-off after entering a transmitting mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdoff <= 1'b0;
    end else if (mode_go) begin
      holdoff <= tx_mode(code_to_mode(mode_request)); // RL13
    end else if (idle_seen) begin
      holdoff <= 1'b0;
    end
  end

  // send request: software sets, engine done or abort clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_send_request <= 1'b0;
    end else if (holdoff && tx_send_request && disable_req_wr) begin
      tx_send_request <= 1'b0; // RL14
    end else if (wr_ok && (paddr == `OFS_STATUS)) begin
      tx_send_request <= pwdata[`ST_SEND_BIT];
    end else if (engine_in.tx_done) begin
      tx_send_request <= 1'b0;
    end
  end

  // aborted flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_aborted_flag <= 1'b0;
    end else if (holdoff && tx_send_request && disable_req_wr) begin
      tx_aborted_flag <= 1'b1; // RL14
    end else if (wr_ok && (paddr == `OFS_STATUS) && pwdata[`ST_ABORT_BIT]) begin
      tx_aborted_flag <= 1'b0;
    end
  end

  // start a frame once the hold-off has passed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_go <= 1'b0;
    end else begin
      tx_go <= tx_mode(mode) && !holdoff && tx_send_request && !engine_in.tx_busy &&
               !tx_go && !mode_go; // RL13
    end
  end

  // =====================================================================
  // wake filter: dominant must persist before it counts as activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_count <= 8'h00;
    end else if (can_receive_pin) begin
      wake_count <= 8'h00;
    end else if (wake_count < 8'(`WAKE_FILT_CYC)) begin
      wake_count <= wake_count + 8'h01;
    end
  end

  // wake flag: only in disable mode, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_flag <= 1'b0;
    end else if ((mode == can_mode_pkg::mode_disable) && !can_receive_pin &&
                 (!(wake_filter_enable && cpu_sleep) ||
                  (wake_count == 8'(`WAKE_FILT_CYC)))) begin
      wake_event_flag <= 1'b1; // RL8 RL12
    end else if (wr_ok && (paddr == `OFS_STATUS) && pwdata[`ST_WAKE_BIT]) begin
      wake_event_flag <= 1'b0;
    end
  end

  // error counter: cleared in init, held in disable, off when listening
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_count <= 8'h00;
    end else if (mode == can_mode_pkg::mode_init) begin
      err_count <= 8'h00; // RL4
    end else if (tx_mode(mode) && engine_in.err_evt && (err_count != `ERR_MAX)) begin
      err_count <= err_count + 8'h01; // RL7 RL16 RL17
    end
  end

  // =====================================================================
  // engine enables per mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctl <= '0;
    end else begin
      mode_ctl.tx_enable <= tx_mode(mode); // RL4 RL7 RL15
      mode_ctl.rx_enable <= (mode != can_mode_pkg::mode_init) &&
                            (mode != can_mode_pkg::mode_disable); // RL4 RL7
      mode_ctl.ack_enable <= tx_mode(mode); // RL17
      mode_ctl.err_flag_enable <= tx_mode(mode); // RL16 RL17
      mode_ctl.keep_on_error <= (mode == can_mode_pkg::mode_listen_all); // RL16
      mode_ctl.loopback <= (mode == can_mode_pkg::mode_loopback); // RL18
    end
  end

  // pin ownership; released pins fall back to port logic outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_transmit_pin <= 1'b1;
      can_transmit_pin_oe <= 1'b0;
      receive_pin_claimed <= 1'b0;
      engine_rx <= 1'b1;
    end else begin
      can_transmit_pin <= engine_in.tx_bit;
      can_transmit_pin_oe <= (mode == can_mode_pkg::mode_normal); // RL11 RL15 RL17 RL18
      receive_pin_claimed <= (mode == can_mode_pkg::mode_normal) ||
                             (mode == can_mode_pkg::mode_listen_only) ||
                             (mode == can_mode_pkg::mode_listen_all); // RL11 RL18
      // loopback feeds the engine its own transmit level
      engine_rx <= mode_ctl.rx_enable ? rx_bus : 1'b1; // RL18
    end
  end

endmodule

// >>> verification/can_mode_sva.sv
// checker for the can operating-mode controller ports
// assumes bit_timing stays at its reset value of 3 during the run
`timescale 1ns/100ps
module can_mode_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and engine
  input wire logic can_receive_pin,
  input wire logic can_transmit_pin,
  input wire logic can_transmit_pin_oe,
  input wire logic receive_pin_claimed,
  input wire can_mode_pkg::engine_in_t engine_in,
  input wire can_mode_pkg::mode_ctl_t mode_ctl,
  input wire logic bit_tick,
  input wire logic tx_go,
  input wire logic engine_rx
);
  // =====================================================================
  // helpers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] entry_run;
  // cycles since transmit was last enabled; once the hold-off is over the bus may be busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_run <= 8'h00;
    end else if (!mode_ctl.tx_enable) begin
      entry_run <= 8'h00;
    end else if (entry_run != 8'hff) begin
      entry_run <= entry_run + 8'h01;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // =====================================================================
  // properties
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_go_single: assert property (tx_go |=> !tx_go)
    else $error("tx_go repeated");
  // 11 bit times of 4 cycles, less one tick phase and the enable lag
  a_go_after_idle: assert property (tx_go |-> entry_run >= 8'h28)
    else $error("tx_go before bus idle");
  a_tx_pin_copy: assert property ($past(presetn) |->
    can_transmit_pin == $past(engine_in.tx_bit))
    else $error("tx pin not a copy of engine bit");
  a_loop_pins_free: assert property (mode_ctl.loopback |->
    !can_transmit_pin_oe && !receive_pin_claimed)
    else $error("pins held in loopback");
  a_offline_rx_idle: assert property (!mode_ctl.rx_enable |=> engine_rx)
    else $error("engine sees bus while offline");
  a_listen_passive: assert property (mode_ctl.rx_enable && !mode_ctl.tx_enable && !mode_ctl.loopback
    && !mode_ctl.keep_on_error |-> !mode_ctl.ack_enable && !mode_ctl.err_flag_enable)
    else $error("listen-only not passive");
  a_oe_claims_rx: assert property (can_transmit_pin_oe |-> receive_pin_claimed)
    else $error("tx driven with rx released");
  a_all_no_drive: assert property (mode_ctl.keep_on_error |-> !can_transmit_pin_oe)
    else $error("listen-all drives tx pin");
  a_tick_period: assert property (bit_tick |=> !bit_tick [*3] ##1 bit_tick)
    else $error("bit tick period wrong");
endmodule
bind can_operating_mode_control can_mode_sva can_mode_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .can_receive_pin(can_receive_pin), .can_transmit_pin(can_transmit_pin),
  .can_transmit_pin_oe(can_transmit_pin_oe), .receive_pin_claimed(receive_pin_claimed),
  .engine_in(engine_in), .mode_ctl(mode_ctl), .bit_tick(bit_tick), .tx_go(tx_go),
  .engine_rx(engine_rx)
);

// >>> verification/can_bus_node.sv
// other nodes on the shared can bus, seen as the receive line
// assumes the caller sits in pclk time; line changes right after an edge
`timescale 1ns/100ps
module can_bus_node (
  // clock
  input wire logic pclk,
  // bus line
  output logic can_receive_pin
);
  // released bus rests recessive through the termination
  initial can_receive_pin = 1'b1;
  // dominant pulses; a gap under 40 cycles keeps the bus from idling
  task automatic burst(input int len, input int gap, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge pclk);
      can_receive_pin <= 1'b0;
      repeat (len) @(posedge pclk);
      can_receive_pin <= 1'b1;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule

// >>> verification/can_operating_mode_control_bench.sv
// self-checking bench for the can operating-mode controller
// assumes the bus node model and the bound checker; engine side driven here
`timescale 1ns/100ps
`include "can_mode_cfg.svh"
module can_operating_mode_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, can_receive_pin, can_transmit_pin, can_transmit_pin_oe;
  logic receive_pin_claimed, engine_rx, bit_tick, tx_go;
  logic cpu_sleep = 1'b0;
  can_mode_pkg::engine_in_t engine_in = 4'h8;
  can_mode_pkg::mode_ctl_t mode_ctl;
  logic [15:0] bit_timing;
  logic [31:0] accept_filter, accept_mask;
  int n_errors = 0, tests_run = 0, go_cnt = 0;
  logic [2:0] codes [3] = '{`CODE_LOOPBACK, `CODE_LISTEN_ONLY, `CODE_LISTEN_ALL};
  // =====================================================================
  // clock, design and far side
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (tx_go === 1'b1) go_cnt++;
  can_operating_mode_control can_operating_mode_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_receive_pin(can_receive_pin), .can_transmit_pin(can_transmit_pin),
    .can_transmit_pin_oe(can_transmit_pin_oe), .receive_pin_claimed(receive_pin_claimed),
    .engine_in(engine_in), .mode_ctl(mode_ctl), .engine_rx(engine_rx), .bit_tick(bit_tick),
    .tx_go(tx_go), .bit_timing(bit_timing), .accept_filter(accept_filter),
    .accept_mask(accept_mask), .cpu_sleep(cpu_sleep));
  can_bus_node can_bus_node_inst (.pclk(pclk), .can_receive_pin(can_receive_pin));
  // =====================================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, s, seen, exp);
    end
  endtask
  // apb cycle; waits for pready under a bound, samples before the edge lands
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic ee);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    // a slave that never answers counts against the run
    if (n == 16) n_errors++;
    q = prdata;
    chk({31'h0, pslverr}, {31'h0, ee}, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    xfer(1'b0, a, 32'h0, ee);
    chk(q, exp, "read data");
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] r, input logic [2:0] s);
    return {21'h0, r, s, 5'h0};
  endfunction
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `OFS_CONTROL_1, 32'h0, 1'b0);
      n++;
    end while (q[7:5] !== m && n < 80);
    chk(32'(q[7:5]), 32'(m), "mode status");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // =====================================================================
  // watchdog: whole sequence needs under a thousand cycles, limit is 20000
  initial begin
    #500000;
    n_errors++;
    report_and_stop;
  end
  // =====================================================================
  // tests
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_CONTROL_1, ctl(`CODE_INIT, `CODE_INIT), 1'b0);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    xfer(1'b1, `OFS_ACCEPT_FILTER, 32'h1234_5678, 1'b0);
    xfer(1'b1, `OFS_ACCEPT_MASK, 32'h00ff_0f0f, 1'b0);
    xfer(1'b1, `OFS_CONFIG_2, 32'h0000_4000, 1'b0);
    rd(`OFS_CONFIG_2, 32'h0000_4000, 1'b0);
    // register outputs change at the commit edge, look half a cycle on
    @(negedge pclk);
    chk(accept_filter, 32'h1234_5678, "filter copy");
    chk(accept_mask, 32'h00ff_0f0f, "mask copy");
    $display("test reset and config done");
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_NORMAL, 3'h7), 1'b0);
    wait_mode(`CODE_NORMAL);
    chk({30'h0, can_transmit_pin_oe, receive_pin_claimed}, 32'h3, "normal pins");
    xfer(1'b1, `OFS_BIT_TIMING, 32'h0000_0007, 1'b1);
    chk({16'h0, bit_timing}, {16'h0, `RESET_TIMING}, "timing locked");
    rd(`OFS_ACCEPT_FILTER, 32'h1234_5678, 1'b0);
    repeat (3) begin
      @(posedge pclk);
      engine_in.err_evt <= 1'b1;
      engine_in.tx_bit <= 1'b0;
      @(posedge pclk);
      engine_in.err_evt <= 1'b0;
      engine_in.tx_bit <= 1'b1;
    end
    rd(`OFS_STATUS, 32'h0000_0300, 1'b0);
    $display("test lock done");
    engine_in.tx_busy <= 1'b1;
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_INIT, 3'h0), 1'b0);
    repeat (100) @(posedge pclk);
    rd(`OFS_CONTROL_1, ctl(`CODE_INIT, `CODE_NORMAL), 1'b0);
    engine_in.tx_busy <= 1'b0;
    wait_mode(`CODE_INIT);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    $display("test busy blocks init done");
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_NORMAL, 3'h0), 1'b0);
    xfer(1'b1, `OFS_STATUS, 32'h4, 1'b0);
    go_cnt = 0;
    repeat (20) @(posedge pclk);
    chk(32'(go_cnt), 32'h0, "early start");
    for (int i = 0; i < 100 && go_cnt == 0; i++) @(posedge pclk);
    chk(32'(go_cnt), 32'h1, "one start");
    engine_in.tx_done <= 1'b1;
    @(posedge pclk);
    engine_in.tx_done <= 1'b0;
    rd(`OFS_STATUS, 32'h0, 1'b0);
    $display("test holdoff done");
    // a dominant bit every 25 cycles keeps the 44-cycle idle count from completing
    can_bus_node_inst.burst(4, 20, 1);
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_DISABLE, 3'h0), 1'b0);
    can_bus_node_inst.burst(4, 20, 7);
    rd(`OFS_CONTROL_1, ctl(`CODE_DISABLE, `CODE_NORMAL), 1'b0);
    wait_mode(`CODE_DISABLE);
    chk({30'h0, can_transmit_pin_oe, receive_pin_claimed}, 32'h0, "disable pins");
    // asleep with the filter on, a short dominant pulse must not wake the module
    cpu_sleep <= 1'b1;
    can_bus_node_inst.burst(3, 3, 1);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    can_bus_node_inst.burst(24, 3, 1);
    rd(`OFS_STATUS, 32'h1, 1'b0);
    xfer(1'b1, `OFS_STATUS, 32'h1, 1'b0);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    $display("test disable and wake done");
    xfer(1'b1, `OFS_CONTROL_1, ctl(3'h5, 3'h0), 1'b0);
    repeat (60) @(posedge pclk);
    rd(`OFS_CONTROL_1, ctl(3'h5, `CODE_DISABLE), 1'b0);
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_NORMAL, 3'h0), 1'b0);
    xfer(1'b1, `OFS_STATUS, 32'h4, 1'b0);
    xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_DISABLE, 3'h0), 1'b0);
    rd(`OFS_STATUS, 32'h2, 1'b0);
    wait_mode(`CODE_DISABLE);
    $display("test abort done");
    foreach (codes[i]) begin
      xfer(1'b1, `OFS_CONTROL_1, ctl(`CODE_INIT, 3'h0), 1'b0);
      wait_mode(`CODE_INIT);
      xfer(1'b1, `OFS_CONTROL_1, ctl(codes[i], 3'h0), 1'b0);
      wait_mode(codes[i]);
      chk({31'h0, can_transmit_pin_oe}, 32'h0, "tx pin released");
      chk({31'h0, receive_pin_claimed}, {31'h0, codes[i] != `CODE_LOOPBACK}, "rx pin");
      chk({31'h0, mode_ctl.loopback}, {31'h0, codes[i] == `CODE_LOOPBACK}, "loop");
      chk({31'h0, mode_ctl.keep_on_error}, {31'h0, codes[i] == `CODE_LISTEN_ALL}, "keep");
    end
    $display("test other modes done");
    report_and_stop;
  end
endmodule
